/* hw/cts_pkg.sv */
package cts_pkg;

  // Trigger source selection
  typedef enum logic [1:0] {
    CTS_SRC_CONTINUOUS = 2'h0,
    CTS_SRC_SOFTWARE = 2'h1,
    CTS_SRC_HARDWARE = 2'h2
  } cts_src_t;

  localparam int CTS_CNT_W = 24;
  localparam int CTS_FRM_W = 8;
  localparam int CTS_GPO_W = 4;
  localparam int CTS_STROBE_GPO_IDX = 0;
  localparam int CTS_SYNC_STAGES = 3;

  localparam logic [CTS_CNT_W-1:0] CTS_CNT_ZERO = 24'h000000;
  localparam logic [CTS_CNT_W-1:0] CTS_CNT_ONE = 24'h000001;
  localparam logic [CTS_FRM_W-1:0] CTS_FRM_ZERO = 8'h00;
  localparam logic [CTS_FRM_W-1:0] CTS_FRM_ONE = 8'h01;

  // Core clock period for converting times to cycles
  localparam int CTS_CLK_PERIOD_NS = 10;

endpackage : cts_pkg

/* hw/cts_debounce.sv */
`timescale 1ns/100ps
`default_nettype none
module cts_debounce
  import cts_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Raw pin and filter setting
  input wire logic pin_in,
  input wire logic [CTS_CNT_W-1:0] debounce_cycles,
  // Filtered level
  output logic level_out
);

  logic [CTS_SYNC_STAGES-1:0] sync_reg;
  logic [CTS_SYNC_STAGES-1:0] sync_next;
  logic [CTS_CNT_W-1:0] stable_reg;
  logic [CTS_CNT_W-1:0] stable_next;
  logic level_reg;
  logic level_next;
  logic agreed;

  // Only stages two and three are looked at; stage one is metastable prone
  assign agreed = sync_reg[1];

  always_comb begin
    sync_next = {sync_reg[CTS_SYNC_STAGES-2:0], pin_in};
    stable_next = stable_reg;
    level_next = level_reg;
    if (sync_reg[1] != sync_reg[2]) begin
      level_next = level_reg;
      stable_next = CTS_CNT_ZERO;
    end else if (debounce_cycles == CTS_CNT_ZERO) begin
      level_next = agreed;
      stable_next = CTS_CNT_ZERO;
    end else if (agreed == level_reg) begin
      stable_next = CTS_CNT_ZERO;
    end else if (stable_reg + CTS_CNT_ONE >= debounce_cycles) begin
      level_next = agreed;
      stable_next = CTS_CNT_ZERO;
    end else begin
      stable_next = stable_reg + CTS_CNT_ONE;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_reg <= '0;
      stable_reg <= CTS_CNT_ZERO;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      stable_reg <= stable_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

  a_level_needs_agree: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(level_reg) |-> $past(sync_reg[1]) == $past(sync_reg[2]))
    else $error("filtered level changed while sync stages disagreed");

  a_zero_passes: assert property (@(posedge core_clk) disable iff (sys_rst)
    (debounce_cycles == CTS_CNT_ZERO && sync_reg[1] == sync_reg[2])
    ##1 (debounce_cycles == CTS_CNT_ZERO) |-> level_reg == $past(sync_reg[1]))
    else $error("zero debounce did not pass the input");

  a_stable_before: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($changed(level_reg) && $past(debounce_cycles) != CTS_CNT_ZERO)
    |-> $past(stable_reg) + CTS_CNT_ONE >= $past(debounce_cycles))
    else $error("level accepted before debounce time");

endmodule : cts_debounce
`default_nettype wire

/* hw/cts_trigger_strobe.sv */
`timescale 1ns/100ps
`default_nettype none
module cts_trigger_strobe
  import cts_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Source and trigger configuration
  input wire logic [1:0] trigger_source,
  input wire logic level_mode,
  input wire logic active_high,
  input wire logic [CTS_CNT_W-1:0] frame_period_cycles,
  input wire logic [CTS_CNT_W-1:0] exposure_cycles,
  input wire logic [CTS_CNT_W-1:0] trigger_delay_cycles,
  input wire logic [CTS_CNT_W-1:0] debounce_cycles,
  input wire logic [CTS_FRM_W-1:0] frames_per_trigger,
  input wire logic [CTS_CNT_W-1:0] frame_interval_cycles,
  // Strobe configuration
  input wire logic strobe_semi_auto,
  input wire logic [CTS_CNT_W-1:0] strobe_delay_time,
  input wire logic [CTS_CNT_W-1:0] strobe_pulse_width,
  // Software command and external pin
  input wire logic sw_trigger,
  input wire logic external_trigger_input,
  // Outputs
  output logic [CTS_GPO_W-1:0] gpo,
  output logic exposure_active,
  output logic frame_start,
  output logic busy
);

  typedef enum logic [2:0] {
    CTS_IDLE,
    CTS_DELAY,
    CTS_EXPOSE,
    CTS_GAP
  } cts_state_t;

  logic trig_level;
  cts_debounce u_debounce (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(external_trigger_input),
    .debounce_cycles(debounce_cycles),
    .level_out(trig_level)
  );

  cts_state_t state_reg, state_next;
  logic [CTS_CNT_W-1:0] cnt_reg, cnt_next;
  logic [CTS_CNT_W-1:0] pace_reg, pace_next;
  logic [CTS_FRM_W-1:0] left_reg, left_next;
  logic prev_reg;
  logic hw_src_reg, hw_src_next;
  logic start_reg, start_next;
  logic str_on_reg, str_on_next;
  logic str_run_reg, str_run_next;
  logic str_ph_reg, str_ph_next;
  logic [CTS_CNT_W-1:0] str_cnt_reg, str_cnt_next;

  logic active_lvl;
  logic edge_hit;
  logic want_cont;
  logic want_sw;
  logic want_hw;
  logic launch;

  // Polarity-corrected level; level-mode active and edge detection share it
  function automatic logic is_active(input logic lvl, input logic hi);
    return hi ? lvl : ~lvl;
  endfunction : is_active

  function automatic logic [CTS_CNT_W-1:0] floor1(input logic [CTS_CNT_W-1:0] v);
    return (v == CTS_CNT_ZERO) ? CTS_CNT_ONE : v;
  endfunction : floor1

  assign active_lvl = is_active(trig_level, active_high);
  assign edge_hit = active_lvl & ~is_active(prev_reg, active_high);
  assign want_cont = (trigger_source == CTS_SRC_CONTINUOUS)
    && (pace_reg == CTS_CNT_ZERO);
  assign want_sw = (trigger_source == CTS_SRC_SOFTWARE) && sw_trigger;
  assign want_hw = (trigger_source == CTS_SRC_HARDWARE)
    && (level_mode ? active_lvl : edge_hit);
  // Only IDLE accepts; a busy engine drops edge and software triggers, while continuous and level requests wait for IDLE
  assign launch = (state_reg == CTS_IDLE) && (want_cont || want_sw || want_hw);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    left_next = left_reg;
    hw_src_next = hw_src_reg;
    start_next = 1'b0;
    pace_next = (pace_reg == CTS_CNT_ZERO) ? CTS_CNT_ZERO : pace_reg - CTS_CNT_ONE;
    unique case (state_reg)
      CTS_IDLE: begin
        if (launch) begin
          hw_src_next = want_hw;
          left_next = (want_hw && !level_mode && frames_per_trigger != CTS_FRM_ZERO)
            ? frames_per_trigger - CTS_FRM_ONE : CTS_FRM_ZERO;
          pace_next = floor1(frame_period_cycles) - CTS_CNT_ONE;
          if (want_hw && trigger_delay_cycles != CTS_CNT_ZERO) begin
            state_next = CTS_DELAY;
            cnt_next = trigger_delay_cycles - CTS_CNT_ONE;
          end else begin
            state_next = CTS_EXPOSE;
            cnt_next = floor1(exposure_cycles) - CTS_CNT_ONE;
            start_next = 1'b1;
          end
        end
      end
      CTS_DELAY: begin
        if (cnt_reg == CTS_CNT_ZERO) begin
          state_next = CTS_EXPOSE;
          cnt_next = floor1(exposure_cycles) - CTS_CNT_ONE;
          start_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - CTS_CNT_ONE;
        end
      end
      CTS_EXPOSE: begin
        if (cnt_reg != CTS_CNT_ZERO) begin
          cnt_next = cnt_reg - CTS_CNT_ONE;
        end else if (left_reg != CTS_FRM_ZERO) begin
          state_next = CTS_GAP;
          cnt_next = frame_interval_cycles;
        end else begin
          // Level mode re-arms from IDLE and checks the level there
          state_next = CTS_IDLE;
        end
      end
      CTS_GAP: begin
        if (cnt_reg == CTS_CNT_ZERO) begin
          state_next = CTS_EXPOSE;
          left_next = left_reg - CTS_FRM_ONE;
          cnt_next = floor1(exposure_cycles) - CTS_CNT_ONE;
          start_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - CTS_CNT_ONE;
        end
      end
      default: state_next = CTS_IDLE;
    endcase
  end

  // Semi-auto strobe: one pulse per accepted trigger, timed from acceptance
  always_comb begin
    str_on_next = str_on_reg;
    str_run_next = str_run_reg;
    str_ph_next = str_ph_reg;
    str_cnt_next = str_cnt_reg;
    if (!strobe_semi_auto) begin
      str_on_next = (state_next == CTS_EXPOSE);
      str_run_next = 1'b0;
    end else if (launch) begin
      str_run_next = 1'b1;
      str_ph_next = (strobe_delay_time == CTS_CNT_ZERO);
      str_on_next = (strobe_delay_time == CTS_CNT_ZERO);
      str_cnt_next = (strobe_delay_time == CTS_CNT_ZERO)
        ? floor1(strobe_pulse_width) - CTS_CNT_ONE : strobe_delay_time - CTS_CNT_ONE;
    end else if (str_run_reg) begin
      if (str_cnt_reg != CTS_CNT_ZERO) begin
        str_cnt_next = str_cnt_reg - CTS_CNT_ONE;
      end else if (!str_ph_reg) begin
        str_ph_next = 1'b1;
        str_on_next = 1'b1;
        str_cnt_next = floor1(strobe_pulse_width) - CTS_CNT_ONE;
      end else begin
        str_on_next = 1'b0;
        str_run_next = 1'b0;
      end
    end else begin
      str_on_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= CTS_IDLE;
      cnt_reg <= CTS_CNT_ZERO;
      pace_reg <= CTS_CNT_ZERO;
      left_reg <= CTS_FRM_ZERO;
      prev_reg <= 1'b0;
      hw_src_reg <= 1'b0;
      start_reg <= 1'b0;
      str_on_reg <= 1'b0;
      str_run_reg <= 1'b0;
      str_ph_reg <= 1'b0;
      str_cnt_reg <= CTS_CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pace_reg <= pace_next;
      left_reg <= left_next;
      prev_reg <= trig_level;
      hw_src_reg <= hw_src_next;
      start_reg <= start_next;
      str_on_reg <= str_on_next;
      str_run_reg <= str_run_next;
      str_ph_reg <= str_ph_next;
      str_cnt_reg <= str_cnt_next;
    end
  end

  // Remaining general outputs are unused by this block
  always_comb begin
    gpo = '0;
    gpo[CTS_STROBE_GPO_IDX] = str_on_reg;
  end
  assign exposure_active = (state_reg == CTS_EXPOSE);
  assign frame_start = start_reg;
  assign busy = (state_reg != CTS_IDLE);

  sequence s_zero_delay_launch;
    launch && want_hw && trigger_delay_cycles == CTS_CNT_ZERO;
  endsequence

  a_reset_continuous: assert property (@(posedge core_clk)
    ($fell(sys_rst) && trigger_source == CTS_SRC_CONTINUOUS)
    |-> !busy ##1 (frame_start && exposure_active))
    else $error("unexpected state after reset");
  a_cont_launch: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_reg == CTS_IDLE && trigger_source == CTS_SRC_CONTINUOUS && pace_reg == CTS_CNT_ZERO)
    |=> exposure_active && frame_start)
    else $error("continuous mode did not start a frame");
  a_sw_launch: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_reg == CTS_IDLE && want_sw) |=> frame_start)
    else $error("software command did not start a frame");
  a_edge_ignored: assert property (@(posedge core_clk) disable iff (sys_rst)
    (edge_hit && state_reg == CTS_EXPOSE && cnt_reg != CTS_CNT_ZERO)
    |=> !frame_start && $stable(left_reg))
    else $error("trigger accepted while busy");
  a_zero_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_zero_delay_launch |=> exposure_active && frame_start)
    else $error("zero delay did not start exposure at once");
  a_delay_wait: assert property (@(posedge core_clk) disable iff (sys_rst)
    (launch && want_hw && trigger_delay_cycles == CTS_CNT_ONE)
    |=> !exposure_active ##1 exposure_active)
    else $error("trigger delay of one cycle not honoured");
  a_auto_strobe: assert property (@(posedge core_clk) disable iff (sys_rst)
    !strobe_semi_auto && !$past(strobe_semi_auto) |-> gpo[0] == exposure_active)
    else $error("automatic strobe not in step with exposure");
  a_semi_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
    (strobe_semi_auto && launch && strobe_delay_time == CTS_CNT_ONE
     && strobe_pulse_width == CTS_CNT_ONE)
    |=> !gpo[0] ##1 gpo[0] ##1 !gpo[0])
    else $error("semi-auto strobe pulse mistimed");
  a_gpo_upper: assert property (@(posedge core_clk) disable iff (sys_rst)
    gpo[CTS_GPO_W-1:1] == '0)
    else $error("strobe leaked onto other outputs");

endmodule : cts_trigger_strobe
`default_nettype wire

/* sim/cts_trig_light_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cts_trig_light_model (
  // Light side
  input wire logic strobe,
  // Trigger pin
  output logic trig_pin
);
  int n_flash = 0;

  initial trig_pin = 1'b0;

  always @(posedge strobe) n_flash++;

  // Glitches shorter than three clocks (23 ns and 17 ns), like a bouncing contact
  task automatic move(input logic lvl, input int bounces);
    for (int i = 0; i < bounces; i++) begin
      trig_pin = lvl;
      #23;
      trig_pin = !lvl;
      #17;
    end
    trig_pin = lvl;
  endtask : move
endmodule : cts_trig_light_model
`default_nettype wire

/* sim/cts_trigger_strobe_test.sv */
`timescale 1ns/100ps
`default_nettype none
module cts_trigger_strobe_test
  import cts_pkg::*;
;
  typedef struct {int lo; int hi; bit rel;} cts_note_t;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic lvl = 1'b0;
  logic act = 1'b1;
  logic semi = 1'b0;
  logic sw = 1'b0;
  logic s_on = 1'b0;
  logic pin;
  logic [1:0] source = 2'h0;
  logic [CTS_CNT_W-1:0] period, expo, tdel, deb, ival, sdel, swid;
  logic [CTS_FRM_W-1:0] nfr = 8'h01;
  logic [CTS_GPO_W-1:0] gpo;
  logic expo_on, fstart, busy;
  int cyc = 0;
  int n_fail = 0;
  int n_tests = 0;
  int last_fs = 0;
  int rise = 0;
  cts_note_t fn, sn;
  cts_note_t fq[$], sq[$];

  cts_trigger_strobe i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .trigger_source(source), .level_mode(lvl),
    .active_high(act), .frame_period_cycles(period), .exposure_cycles(expo),
    .trigger_delay_cycles(tdel), .debounce_cycles(deb), .frames_per_trigger(nfr),
    .frame_interval_cycles(ival), .strobe_semi_auto(semi), .strobe_delay_time(sdel),
    .strobe_pulse_width(swid), .sw_trigger(sw), .external_trigger_input(pin),
    .gpo(gpo), .exposure_active(expo_on), .frame_start(fstart), .busy(busy)
  );
  cts_trig_light_model i_light (.strobe(gpo[0]), .trig_pin(pin));

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic chk(string what, int lo, int hi, int got);
    n_tests++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk

  task automatic chk_bits(string what, logic [6:0] exp, logic [6:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_bits

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // Automatic strobe is expected to mirror every frame exactly
  task automatic note(int lo, int hi, bit rel);
    fq.push_back('{lo, hi, rel});
    if (!semi) sq.push_back('{0, int'(expo), 1'b0});
  endtask : note

  // Second edge lands in exposure or inside the debounce time
  task automatic hw_edge(logic pol, int d, int db, int n, int b);
    act = pol;
    tdel = 24'(d);
    deb = 24'(db);
    nfr = 8'(n);
    i_light.move(!pol, 0);
    tick(40);
    i_light.move(pol, b);
    note(cyc + d + db + 3, cyc + d + db + 8, 0);
    for (int i = 1; i < n; i++) note(expo + ival + 1, expo + ival + 2, 1);
    tick(12);
    i_light.move(!pol, 0);
    tick(4);
    i_light.move(pol, 0);
    tick(d + n * (expo + ival + 3) + 60);
  endtask : hw_edge

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // One block so frame and strobe timing share the same last_fs
  always @(posedge core_clk) begin
    if (fstart === 1'b1) begin
      if (fq.size() == 0) chk("frame_start extra", 1, 0, cyc);
      else begin
        fn = fq.pop_front();
        chk("frame_start cycle", fn.lo + (fn.rel ? last_fs : 0), fn.hi + (fn.rel ? last_fs : 0), cyc);
      end
      last_fs = cyc;
    end
    if (gpo[0] === 1'b1 && !s_on) begin
      s_on = 1'b1;
      rise = cyc;
    end
    if (gpo[0] !== 1'b1 && s_on) begin
      s_on = 1'b0;
      if (sq.size() == 0) chk("strobe extra", 1, 0, cyc);
      else begin
        sn = sq.pop_front();
        chk("strobe offset", sn.lo, sn.lo, rise - last_fs);
        chk("strobe width", sn.hi, sn.hi, cyc - rise);
      end
      chk_bits("gpo upper", 7'h00, {4'h0, gpo[3:1]});
    end
  end

  initial begin
    void'($urandom(94));
    period = 24'(16 + $urandom_range(15));
    expo = 24'(2 + $urandom_range(7));
    tdel = 24'h0;
    deb = 24'h0;
    ival = 24'h4;
    sdel = 24'h0;
    swid = 24'h1;
    fork
      begin
        tick(20000);
        n_fail++;
        tally_and_finish();
      end
    join_none
    tick(10);
    chk_bits("outputs in reset", 7'h00, {gpo, expo_on, fstart, busy});
    sys_rst = 1'b0;
    note(cyc, cyc + 4, 0);
    for (int i = 0; i < 3; i++) note(period, period, 1);
    tick(3 * period + expo + 4);
    $display("continuous done");
    source = 2'h1;
    expo = 24'hc;
    for (int k = 0; k < 4; k++) begin
      semi = (k > 0);
      sdel = (k == 3) ? 24'h1 : (k == 2) ? 24'($urandom_range(6)) : 24'h0;
      swid = (k == 3) ? 24'h1 : 24'(1 + $urandom_range(3));
      note(cyc + 1, cyc + 1, 0);
      if (semi) sq.push_back('{int'(sdel), int'(swid), 1'b0});
      sw = 1'b1;
      tick(1);
      sw = 1'b0;
      tick(2);
      // Repeat command while exposing must be dropped
      sw = 1'b1;
      tick(1);
      sw = 1'b0;
      tick(30);
    end
    $display("software done");
    source = 2'h2;
    semi = 1'b0;
    expo = 24'h28;
    // Long exposure so the bench's second edge is always dropped
    hw_edge(1'b1, 1, 0, 1, 0);
    hw_edge(1'b1, 0, 0, 1, 0);
    expo = 24'h6;
    hw_edge(1'b0, 7, 8, 3, 3);
    $display("edge done");
    lvl = 1'b1;
    act = 1'b1;
    tdel = 24'h0;
    deb = 24'h0;
    expo = 24'ha;
    tick(5);
    i_light.move(1'b1, 0);
    note(cyc + 3, cyc + 8, 0);
    note(11, 11, 1);
    note(11, 11, 1);
    tick(32);
    i_light.move(1'b0, 0);
    tick(40);
    $display("level done");
    source = 2'h3;
    tick(20);
    chk("notes left", 0, 0, fq.size() + sq.size());
    tally_and_finish();
  end
endmodule : cts_trigger_strobe_test
`default_nettype wire
